/* core/drive_cmd_defines.svh */
// Constants for the drive run and frequency command block.
// Assumes inclusion by bare name from the package and from design modules.
`ifndef DRIVE_CMD_DEFINES_SVH
`define DRIVE_CMD_DEFINES_SVH
// Frequencies are in units of 0.01 Hz, times in units of 0.1 s
`define FREQ_W 17
`define FREQ_MAX 17'h0_FDE8
`define LOWER_MAX 17'h0_FDE7
`define UPPER_MIN 17'h0_0001
`define TIME_W 16
`define TIME_MIN 16'h0_001
`define TIME_MAX 16'h8_CA0
`define FUNC_FWD 5'h00
`define FUNC_REV 5'h01
`define FUNC_ALT_SRC 5'h0D
`define NUM_INPUTS 5
// Ramp step: 0.01 Hz step enable from a 1 ms tick (10 MHz clock)
`define CLK_HZ 10000000
`define TICK_US 1000
`define TICK_CYCLES ((`CLK_HZ / 1000000) * `TICK_US)
`endif

/* core/drive_cmd_pkg.sv */
// Types for the drive run and frequency command block.
// Assumes drive_cmd_defines.svh is on the include path.
`include "drive_cmd_defines.svh"
package drive_cmd_pkg;
   // ==========================================
   // Terminal operation modes
   typedef enum logic [1:0] {
      TERM_FWD_REV = 2'b00,
      TERM_RUN_DIR = 2'b01,
      TERM_THREE_WIRE = 2'b10
   } term_mode_t;
   // Frequency sources
   typedef enum logic [2:0] {
      SRC_KEYPAD_UPDN = 3'b000,
      SRC_KEYPAD_POT = 3'b001,
      SRC_VOLTAGE = 3'b010,
      SRC_CURRENT = 3'b011,
      SRC_EXT_UPDN = 3'b100,
      SRC_COMM = 3'b101,
      SRC_PID = 3'b110
   } freq_src_t;
   typedef enum logic [1:0] {
      INIT_CURRENT = 2'b00,
      INIT_ZERO = 2'b01,
      INIT_SETPOINT = 2'b10
   } init_sel_t;
   // Source values grouped together
   typedef struct packed {
      logic [`FREQ_W-1:0] keypad_updn;
      logic [`FREQ_W-1:0] keypad_pot;
      logic [`FREQ_W-1:0] voltage_in;
      logic [`FREQ_W-1:0] current_in;
      logic [`FREQ_W-1:0] ext_updn;
      logic [`FREQ_W-1:0] comm;
      logic [`FREQ_W-1:0] pid;
   } freq_sources_t;
   // Four ramp times, 0.1 s units
   typedef struct packed {
      logic [`TIME_W-1:0] accel1;
      logic [`TIME_W-1:0] decel1;
      logic [`TIME_W-1:0] accel2;
      logic [`TIME_W-1:0] decel2;
   } ramp_times_t;
endpackage : drive_cmd_pkg

/* core/freq_source_mux.sv */
// Frequency source selector for one selector setting.
// Assumes all sources are already in 0.01 Hz units.
`timescale 1ns/1ps
`default_nettype none
`include "drive_cmd_defines.svh"
module freq_source_mux (
   input wire drive_cmd_pkg::freq_src_t sel,
   input wire drive_cmd_pkg::freq_sources_t src,
   output logic [`FREQ_W-1:0] value
);
   // ==========================================
   // Decode
   // R9 - source decode
   always_comb begin
      value = '0;
      unique case (sel)
         drive_cmd_pkg::SRC_KEYPAD_UPDN: value = src.keypad_updn;
         drive_cmd_pkg::SRC_KEYPAD_POT: value = src.keypad_pot;
         drive_cmd_pkg::SRC_VOLTAGE: value = src.voltage_in;
         drive_cmd_pkg::SRC_CURRENT: value = src.current_in;
         drive_cmd_pkg::SRC_EXT_UPDN: value = src.ext_updn;
         drive_cmd_pkg::SRC_COMM: value = src.comm;
         drive_cmd_pkg::SRC_PID: value = src.pid;
         default: value = '0; // Code 7 is illegal, gives zero
      endcase
   end
endmodule : freq_source_mux
`default_nettype wire

/* core/drive_run_and_frequency_command.sv */
// Run, stop, direction and frequency command logic of a motor drive.
// Assumes settings are static ports held by firmware; inputs synchronous.
// Contract
// R1 - Terminal mode 0 fwd/rev switches, 1 run plus direction, 2 three-wire.
// R2 - Mode 0: function 0 input closed runs forward, open stops.
// R3 - Mode 0: function 1 input closed runs reverse, open stops.
// R4 - Mode 1: function 0 input is maintained run/stop switch.
// R5 - Mode 1: function 1 input off forward, on reverse.
// R6 - Mode 2: momentary run button starts, separate button stops.
// R7 - Mode 2: function assignments ignored, inputs 1 to 3 fixed roles.
// R8 - Mode 2: stop button normally closed; run only while it is closed.
// R9 - Source selector codes 0 to 6 choose the seven sources.
// R10 - Combine 0: main source, alternative while function 13 active.
// R11 - Combine 1: command is main plus alternative.
// R12 - Comm frequency readable as set frequency, used only when selected.
// R13 - Power down saves keypad frequency (0) or comm frequency (1).
// R14 - Keypad initial frequency: current command, zero, or stored setpoint.
// R15 - Lower limit and command both zero: run gives no output, stop shown.
// R16 - Command above lower limit: ramp from zero up to command.
// R17 - Lower limit nonzero, command at or below it: start at lower limit.
// R18 - Two accel and two decel times, 0.1 to 3600.0 s.
// R19 - Actual ramp time scales by (set minus start frequency) over max.
// R20 - Upper limit 0.01 to 650.00 Hz, lower 0.00 to 649.99 Hz.
// R21 - Frequency command clamped to upper limit before the ramp.
`timescale 1ns/1ps
`default_nettype none
`include "drive_cmd_defines.svh"
module drive_run_and_frequency_command (
   input wire logic clock,
   input wire logic rst,
   // Multifunction inputs, bit 0 is input 1, high means closed
   input wire logic [`NUM_INPUTS-1:0] multifunction_input,
   input wire logic [`NUM_INPUTS*5-1:0] input_function,
   input wire drive_cmd_pkg::term_mode_t term_mode,
   input wire drive_cmd_pkg::freq_src_t main_src_sel,
   input wire drive_cmd_pkg::freq_src_t alt_src_sel,
   input wire logic combine_sum,
   input wire drive_cmd_pkg::freq_sources_t sources,
   input wire logic save_comm,
   input wire logic power_down,
   input wire drive_cmd_pkg::init_sel_t init_sel,
   input wire logic [`FREQ_W-1:0] init_setpoint,
   input wire logic [`FREQ_W-1:0] upper_limit,
   input wire logic [`FREQ_W-1:0] lower_limit,
   input wire logic [`FREQ_W-1:0] start_freq,
   input wire logic [`FREQ_W-1:0] max_out_freq,
   input wire drive_cmd_pkg::ramp_times_t ramp_times,
   input wire logic ramp_set2,
   output logic run_active,
   output logic reverse,
   output logic stop_shown,
   output logic [`FREQ_W-1:0] freq_command,
   output logic [`FREQ_W-1:0] output_freq,
   output logic [`FREQ_W-1:0] set_freq_readback,
   output logic [`FREQ_W-1:0] saved_freq,
   output logic [`FREQ_W-1:0] keypad_initial,
   output logic [`TIME_W-1:0] actual_accel,
   output logic [`TIME_W-1:0] actual_decel
);
   // ==========================================
   // Input function decode
   logic [`NUM_INPUTS-1:0] is_fwd;
   logic [`NUM_INPUTS-1:0] is_rev;
   logic [`NUM_INPUTS-1:0] is_alt;
   genvar gi;
   // Per-input function match, one generate entry per input
   generate
      for (gi = 0; gi < `NUM_INPUTS; gi = gi + 1) begin : g_func
         assign is_fwd[gi] = input_function[gi*5 +: 5] == `FUNC_FWD;
         assign is_rev[gi] = input_function[gi*5 +: 5] == `FUNC_REV;
         assign is_alt[gi] = input_function[gi*5 +: 5] == `FUNC_ALT_SRC;
      end
   endgenerate
   logic fwd_closed;
   logic rev_closed;
   logic alt_active;
   // Any input with the function that is closed
   assign fwd_closed = |(is_fwd & multifunction_input);
   assign rev_closed = |(is_rev & multifunction_input);
   // R10 - alternative switch input
   assign alt_active = |(is_alt & multifunction_input)
      && term_mode != drive_cmd_pkg::TERM_THREE_WIRE;

   // ==========================================
   // Run request decode
   logic run_req;
   logic dir_req;
   logic latch_r;
   logic dir3_r;
   // Three-wire latch: input 1 run, input 2 stop (NC), input 3 direction
   // R7 - fixed roles in three-wire
   // R6 - momentary start and stop
   always_ff @(posedge clock) begin
      if (rst) begin
         latch_r <= 1'b0;
      end else if (term_mode != drive_cmd_pkg::TERM_THREE_WIRE) begin
         latch_r <= 1'b0;
      end else if (!multifunction_input[1]) begin
         // R8 - open stop contact wins
         latch_r <= 1'b0;
      end else if (multifunction_input[0]) begin
         latch_r <= 1'b1;
      end
   end
   // Direction input sampled at run start so it cannot flip mid-run
   always_ff @(posedge clock) begin
      if (rst) begin
         dir3_r <= 1'b0;
      end else if (!latch_r) begin
         dir3_r <= multifunction_input[2];
      end
   end
   // R1 - terminal mode decode
   always_comb begin
      run_req = 1'b0;
      dir_req = 1'b0;
      unique case (term_mode)
         drive_cmd_pkg::TERM_FWD_REV: begin
            // R2 - forward switch
            // R3 - reverse switch; both closed is treated as stop
            run_req = fwd_closed ^ rev_closed;
            dir_req = rev_closed;
         end
         drive_cmd_pkg::TERM_RUN_DIR: begin
            // R4 - maintained run switch
            run_req = fwd_closed;
            // R5 - off forward, on reverse
            dir_req = rev_closed;
         end
         drive_cmd_pkg::TERM_THREE_WIRE: begin
            run_req = latch_r;
            dir_req = dir3_r;
         end
         default: begin
            run_req = 1'b0;
            dir_req = 1'b0;
         end
      endcase
   end

   // ==========================================
   // Frequency command path
   logic [`FREQ_W-1:0] main_val;
   logic [`FREQ_W-1:0] alt_val;
   logic [`FREQ_W:0] sum_val;
   logic [`FREQ_W-1:0] cmd_nxt;
   logic [`FREQ_W-1:0] upper_eff;
   logic [`FREQ_W-1:0] lower_eff;
   freq_source_mux u_main (
      .sel(main_src_sel),
      .src(sources),
      .value(main_val)
   );
   freq_source_mux u_alt (
      .sel(alt_src_sel),
      .src(sources),
      .value(alt_val)
   );
   // R20 - limit ranges enforced on the settings
   always_comb begin
      upper_eff = upper_limit;
      if (upper_limit < `UPPER_MIN) upper_eff = `UPPER_MIN;
      if (upper_limit > `FREQ_MAX) upper_eff = `FREQ_MAX;
      lower_eff = (lower_limit > `LOWER_MAX) ? `LOWER_MAX : lower_limit;
   end
   // Combination and clamp
   always_comb begin
      sum_val = {1'b0, main_val} + {1'b0, alt_val};
      cmd_nxt = main_val;
      if (combine_sum) begin
         // R11 - sum of main and alternative
         cmd_nxt = sum_val[`FREQ_W-1:0];
         if (sum_val[`FREQ_W]) cmd_nxt = upper_eff;
      end else if (alt_active) begin
         // R10 - alternative while switched
         cmd_nxt = alt_val;
      end
      // R21 - clamp to upper limit
      if (cmd_nxt > upper_eff) cmd_nxt = upper_eff;
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         freq_command <= '0;
      end else begin
         freq_command <= cmd_nxt;
      end
   end
   // R12 - comm readback, only comm selection uses it (via mux)
   always_ff @(posedge clock) begin
      if (rst) begin
         set_freq_readback <= '0;
      end else begin
         set_freq_readback <= (sources.comm > `FREQ_MAX) ? `FREQ_MAX : sources.comm;
      end
   end
   // R13 - save on power down
   always_ff @(posedge clock) begin
      if (rst) begin
         saved_freq <= '0;
      end else if (power_down) begin
         saved_freq <= save_comm ? sources.comm : sources.keypad_updn;
      end
   end
   // R14 - keypad initial frequency
   always_ff @(posedge clock) begin
      if (rst) begin
         keypad_initial <= '0;
      end else begin
         unique case (init_sel)
            drive_cmd_pkg::INIT_CURRENT: keypad_initial <= freq_command;
            drive_cmd_pkg::INIT_ZERO: keypad_initial <= '0;
            drive_cmd_pkg::INIT_SETPOINT: keypad_initial <= init_setpoint;
            default: keypad_initial <= '0;
         endcase
      end
   end

   // ==========================================
   // Ramp times
   logic [`TIME_W-1:0] acc_sel;
   logic [`TIME_W-1:0] dec_sel;
   logic [`FREQ_W-1:0] span;
   logic [`TIME_W+`FREQ_W-1:0] acc_prod;
   logic [`TIME_W+`FREQ_W-1:0] dec_prod;
   logic [`TIME_W+`FREQ_W-1:0] max_div;
   // R18 - two sets, clipped to 0.1 .. 3600.0 s
   always_comb begin
      acc_sel = ramp_set2 ? ramp_times.accel2 : ramp_times.accel1;
      dec_sel = ramp_set2 ? ramp_times.decel2 : ramp_times.decel1;
      if (acc_sel < `TIME_MIN) acc_sel = `TIME_MIN;
      if (acc_sel > `TIME_MAX) acc_sel = `TIME_MAX;
      if (dec_sel < `TIME_MIN) dec_sel = `TIME_MIN;
      if (dec_sel > `TIME_MAX) dec_sel = `TIME_MAX;
   end
   // R19 - scale by span over max frequency; divider kept combinational
   always_comb begin
      span = (freq_command > start_freq) ? freq_command - start_freq : '0;
      acc_prod = acc_sel * span;
      dec_prod = dec_sel * span;
      max_div = {{`TIME_W{1'b0}}, (max_out_freq == '0) ? `UPPER_MIN : max_out_freq};
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         actual_accel <= '0;
         actual_decel <= '0;
      end else begin
         actual_accel <= `TIME_W'(acc_prod / max_div);
         actual_decel <= `TIME_W'(dec_prod / max_div);
      end
   end

   // ==========================================
   // Ramp generator, one 0.01 Hz step per tick
   logic [15:0] tick_cnt_r;
   logic tick;
   logic running_r;
   assign tick = tick_cnt_r == 16'(`TICK_CYCLES - 1);
   always_ff @(posedge clock) begin
      if (rst || tick) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 16'h0001;
      end
   end
   logic zero_case;
   // R15 - nothing to run at zero limit and zero command
   assign zero_case = lower_eff == '0 && freq_command == '0;
   always_ff @(posedge clock) begin
      if (rst) begin
         running_r <= 1'b0;
         output_freq <= '0;
         reverse <= 1'b0;
      end else if (!running_r) begin
         if (run_req && !zero_case) begin
            running_r <= 1'b1;
            reverse <= dir_req;
            // R17 - start at lower limit when command at or below it
            // R16 - otherwise ramp from zero
            output_freq <= (lower_eff != '0 && freq_command <= lower_eff) ?
               lower_eff : '0;
         end
      end else if (tick) begin
         if (!run_req) begin
            if (output_freq == '0) running_r <= 1'b0;
            else output_freq <= output_freq - 17'h0_0001;
         end else if (output_freq < freq_command) begin
            output_freq <= output_freq + 17'h0_0001;
         end else if (output_freq > freq_command) begin
            output_freq <= output_freq - 17'h0_0001;
         end
      end
   end
   assign run_active = running_r;
   // R15 - stop indication
   assign stop_shown = !running_r;
endmodule : drive_run_and_frequency_command
`default_nettype wire

/* tb/operator_panel.sv */
// Operator switches and push buttons wired to the multifunction inputs.
// Assumes the bench sets the wanted contact states; contacts settle late.
`timescale 1ns/1ps
`default_nettype none
module operator_panel (
   input wire logic clock,
   input wire logic three_wire,
   input wire logic [4:0] switch_want,
   input wire logic press_run,
   input wire logic press_stop,
   input wire logic [3:0] settle,
   output logic [4:0] contacts
);
   logic [4:0] want;
   logic [3:0] cnt_r = 4'h0;
   assign want = three_wire ? {switch_want[4:2], !press_stop, press_run} : switch_want;
   // Contact bounce modelled as a settle delay, so slow panels are exercised
   always @(posedge clock) begin
      if (want == contacts || cnt_r >= settle) begin
         cnt_r <= 4'h0;
         contacts <= want;
      end else begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule : operator_panel
`default_nettype wire

/* tb/drive_cmd_checker.sv */
// Port assertions for the run and frequency command block.
// Assumes a single clock domain; bound to the top module below.
`timescale 1ns/1ps
`default_nettype none
module drive_cmd_checker (
   input wire logic clock,
   input wire logic rst,
   input wire drive_cmd_pkg::freq_sources_t sources,
   input wire logic save_comm,
   input wire logic power_down,
   input wire logic [16:0] upper_limit,
   input wire logic [16:0] lower_limit,
   input wire logic run_active,
   input wire logic reverse,
   input wire logic stop_shown,
   input wire logic [16:0] freq_command,
   input wire logic [16:0] output_freq,
   input wire logic [16:0] set_freq_readback,
   input wire logic [16:0] saved_freq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ==========================================
   // Run state
   stop_inverse_a: assert property (stop_shown == !run_active)
      else $error("stop flag not inverse of run");
   zero_refuse_a: assert property (lower_limit == 0 && freq_command == 0 && !run_active
      |=> !run_active) else $error("run started at zero command");
   start_zero_a: assert property (!run_active && freq_command > lower_limit ##1 run_active
      |-> output_freq == 0) else $error("start not at zero");
   start_lower_a: assert property (!run_active && lower_limit != 0
      && freq_command <= lower_limit ##1 run_active |-> output_freq == $past(lower_limit))
      else $error("start not at lower limit");
   ramp_step_a: assert property (run_active[*2] |-> output_freq == $past(output_freq)
      || output_freq == $past(output_freq) + 1 || output_freq + 1 == $past(output_freq))
      else $error("ramp jumped");
   dir_hold_a: assert property (run_active[*2] |-> $stable(reverse))
      else $error("direction changed while running");
   // ==========================================
   // Frequency values
   clamp_upper_a: assert property (upper_limit != 0
      |=> freq_command <= $past(upper_limit)) else $error("command above upper limit");
   readback_a: assert property (sources.comm <= 17'h0_FDE8
      |=> set_freq_readback == $past(sources.comm)) else $error("readback wrong");
   save_keypad_a: assert property (power_down && !save_comm
      |=> saved_freq == $past(sources.keypad_updn)) else $error("keypad not saved");
   save_comm_a: assert property (power_down && save_comm
      |=> saved_freq == $past(sources.comm)) else $error("comm not saved");
   run_c: cover property ($rose(run_active));
   rev_c: cover property (run_active && reverse);
   save_c: cover property (power_down && save_comm);
endmodule : drive_cmd_checker
bind drive_run_and_frequency_command drive_cmd_checker u_chk (.clock(clock), .rst(rst),
   .sources(sources), .save_comm(save_comm), .power_down(power_down),
   .upper_limit(upper_limit), .lower_limit(lower_limit), .run_active(run_active),
   .reverse(reverse), .stop_shown(stop_shown), .freq_command(freq_command),
   .output_freq(output_freq), .set_freq_readback(set_freq_readback),
   .saved_freq(saved_freq));
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the run and frequency command block.
// Assumes the design, panel model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
$display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb;
   typedef struct {int id; logic [16:0] e;} note_t;
   note_t notes[$];
   event look;
   int miscompares = 0;
   int total_checks = 0;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic comb = 1'b0, save_comm = 1'b0, pdown = 1'b0, ramp2 = 1'b0;
   logic three_w = 1'b0, prun = 1'b0, pstop = 1'b0, run, rev, stop;
   logic [4:0] want = 5'h00, mfi;
   logic [3:0] settle = 4'h0;
   logic [24:0] func = 25'h21_3420;
   logic [7:0] lfsr = 8'h55;
   logic [16:0] isp = 17'h0_0777, upper = 17'h0_FDE8, lower = 17'h0_0000;
   logic [16:0] sfreq = 17'h0_0000;
   logic [16:0] maxf = 17'h0_000A, fcmd, ofreq, rdbk, saved, kinit;
   logic [15:0] acc, dec;
   logic [169:0] outs;
   drive_cmd_pkg::term_mode_t mode = drive_cmd_pkg::TERM_FWD_REV;
   drive_cmd_pkg::freq_src_t msel = drive_cmd_pkg::SRC_KEYPAD_UPDN;
   drive_cmd_pkg::freq_src_t asel = drive_cmd_pkg::SRC_COMM;
   drive_cmd_pkg::init_sel_t isel = drive_cmd_pkg::INIT_CURRENT;
   drive_cmd_pkg::freq_sources_t src = '0;
   drive_cmd_pkg::ramp_times_t rt = {16'h0064, 16'h00C8, 16'h0028, 16'h003C};
   string names[10] = '{"run", "reverse", "stop", "command", "output", "readback",
      "saved", "initial", "accel", "decel"};
   assign outs = {1'b0, dec, 1'b0, acc, kinit, saved, rdbk, ofreq, fcmd, 16'h0000, stop,
      16'h0000, rev, 16'h0000, run};
   operator_panel u_panel (.clock(clock), .three_wire(three_w), .switch_want(want),
      .press_run(prun), .press_stop(pstop), .settle(settle), .contacts(mfi));
   drive_run_and_frequency_command u_dut (.clock(clock), .rst(rst),
      .multifunction_input(mfi), .input_function(func), .term_mode(mode),
      .main_src_sel(msel), .alt_src_sel(asel), .combine_sum(comb), .sources(src),
      .save_comm(save_comm), .power_down(pdown), .init_sel(isel), .init_setpoint(isp),
      .upper_limit(upper), .lower_limit(lower), .start_freq(sfreq),
      .max_out_freq(maxf), .ramp_times(rt), .ramp_set2(ramp2), .run_active(run),
      .reverse(rev), .stop_shown(stop), .freq_command(fcmd), .output_freq(ofreq),
      .set_freq_readback(rdbk), .saved_freq(saved), .keypad_initial(kinit),
      .actual_accel(acc), .actual_decel(dec));
   // ==========================================
   // Clock, watchdog and result checking
   always #50 clock = !clock;
   // Runs take up to one ramp tick each; the cap sits well past that
   initial begin
      repeat (90000) @(posedge clock);
      miscompares++;
      end_sim();
   end
   // Oldest note first, once the driver says outputs are settled
   always @(look) begin
      while (notes.size() > 0) begin
         `CHK(names[notes[0].id], notes[0].e, outs[notes[0].id * 17 +: 17])
         void'(notes.pop_front());
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   task automatic note(input int id, input logic [16:0] e);
      notes.push_back('{id, e});
   endtask : note
   task automatic at(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : at
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr_next
   function automatic logic [16:0] pick(input int k);
      return src[(6 - k) * 17 +: 17];
   endfunction : pick
   // Stop takes up to one ramp tick, so the wait is bounded past it
   task automatic wait_stop();
      for (int i = 0; i < 12000 && run !== 1'b0; i++) @(posedge clock);
      at(1);
      note(0, 17'h0_0000);
      ->look;
   endtask : wait_stop
   task automatic run_case(input logic [4:0] w1, input logic [4:0] w2, input logic rv);
      @(posedge clock);
      want <= w1;
      at(8);
      note(0, 17'h0_0001);
      note(1, {16'h0000, rv});
      ->look;
      @(posedge clock);
      want <= w2;
      wait_stop();
      $display("run case %h done", w1);
   endtask : run_case
   // ==========================================
   // Main sequence
   initial begin
      for (int j = 0; j < 7; j++) begin
         lfsr = lfsr_next(lfsr);
         src[j * 17 +: 17] = {9'h000, lfsr};
      end
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      for (int k = 0; k < 7; k++) begin
         @(posedge clock);
         msel <= drive_cmd_pkg::freq_src_t'(k);
         at(3);
         note(3, pick(k));
         ->look;
      end
      @(posedge clock);
      want <= 5'h04;
      at(3);
      note(3, pick(5));
      ->look;
      @(posedge clock);
      comb <= 1'b1;
      want <= 5'h00;
      at(3);
      note(3, pick(6) + pick(5));
      ->look;
      @(posedge clock);
      upper <= 17'h0_0000;
      at(3);
      note(3, 17'h0_0001);
      ->look;
      @(posedge clock);
      upper <= 17'h0_0005;
      at(4);
      note(3, 17'h0_0005);
      note(8, 17'h0_0032);
      note(9, 17'h0_0064);
      ->look;
      @(posedge clock);
      ramp2 <= 1'b1;
      at(4);
      note(8, 17'h0_0014);
      note(9, 17'h0_001E);
      ->look;
      // Nonzero start frequency shrinks the span: 5 - 2 = 3
      @(posedge clock);
      sfreq <= 17'h0_0002;
      at(4);
      note(8, 17'h0_000C);
      note(9, 17'h0_0012);
      ->look;
      for (int k = 0; k < 3; k++) begin
         @(posedge clock);
         isel <= drive_cmd_pkg::init_sel_t'(k);
         at(3);
         note(7, k == 0 ? 17'h0_0005 : k == 1 ? 17'h0_0000 : isp);
         ->look;
      end
      @(posedge clock);
      src.comm <= 17'h0_1234;
      pdown <= 1'b1;
      at(3);
      note(5, 17'h0_1234);
      note(6, pick(0));
      ->look;
      @(posedge clock);
      save_comm <= 1'b1;
      at(3);
      note(6, 17'h0_1234);
      ->look;
      pdown <= 1'b0;
      $display("setting tests done");
      run_case(5'h01, 5'h00, 1'b0);
      run_case(5'h02, 5'h00, 1'b1);
      mode <= drive_cmd_pkg::TERM_RUN_DIR;
      settle <= 4'h3;
      run_case(5'h03, 5'h02, 1'b1);
      run_case(5'h01, 5'h00, 1'b0);
      @(posedge clock);
      mode <= drive_cmd_pkg::TERM_THREE_WIRE;
      three_w <= 1'b1;
      func <= 25'hD6_B5AD;
      pstop <= 1'b1;
      prun <= 1'b1;
      want <= 5'h04;
      at(8);
      note(0, 17'h0_0000);
      ->look;
      prun <= 1'b0;
      pstop <= 1'b0;
      at(6);
      prun <= 1'b1;
      at(6);
      prun <= 1'b0;
      at(6);
      note(0, 17'h0_0001);
      note(1, 17'h0_0001);
      ->look;
      pstop <= 1'b1;
      wait_stop();
      $display("three wire done");
      mode <= drive_cmd_pkg::TERM_FWD_REV;
      three_w <= 1'b0;
      func <= 25'h21_3420;
      comb <= 1'b0;
      // Alternative switch must open, else it feeds a nonzero command
      want <= 5'h00;
      msel <= drive_cmd_pkg::freq_src_t'(3'h7);
      at(8);
      want <= 5'h01;
      at(8);
      note(0, 17'h0_0000);
      note(2, 17'h0_0001);
      ->look;
      lower <= 17'h0_0009;
      msel <= drive_cmd_pkg::SRC_PID;
      want <= 5'h00;
      at(12);
      want <= 5'h01;
      at(8);
      note(4, 17'h0_0009);
      ->look;
      rst <= 1'b1;
      at(2);
      note(0, 17'h0_0000);
      note(4, 17'h0_0000);
      ->look;
      $display("limit tests done");
      at(1);
      end_sim();
   end
endmodule : tb
`default_nettype wire
